// *** hdl/llar_defines.svh ***
/*
 * Register indices, field positions, reset values and timing constants of the LOF alarm block.
 * Assumes inclusion by the core and the bench; definitions only.
 */
`ifndef LLAR_DEFINES_SVH
`define LLAR_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define LLAR_IDX_DEFECT    16'h1107
`define LLAR_IDX_EVENT     16'h110b
`define LLAR_IDX_INSYNC    16'h112b
`define LLAR_IDX_MASK      16'h110f
`define LLAR_IDX_MODE      16'h1100
`define LLAR_IDX_AUTO      16'h1163
`define LLAR_IDX_RDI       16'h1933

`define LLAR_RST_AUTO      8'h05
`define LLAR_RST_RDI       4'h2
`define LLAR_RST_MASK      8'hff
`define LLAR_RST_INSYNC    4'h0

// Bit positions of the defect and event bytes; LOS, SEF and LOF share theirs.
`define LLAR_B_LOS         0
`define LLAR_B_SEF         1
`define LLAR_B_LOF         2
`define LLAR_B_B1          3
`define LLAR_B_B2          4
`define LLAR_B_REI         5
`define LLAR_B_SD          3
`define LLAR_B_SF          4
// Change bits of SD and SF sit apart from their defect positions in the event byte.
`define LLAR_E_SD          6
`define LLAR_E_SF          7

// Control bits of the automatic alarm and remote defect registers.
`define LLAR_A_MASTER      0
`define LLAR_A_LOS         1
`define LLAR_A_LOF         2
`define LLAR_A_LOC         3
`define LLAR_A_SD          4
`define LLAR_A_SF          5
`define LLAR_A_TIM         6
`define LLAR_A_TIU         7
`define LLAR_R_LOS         0
`define LLAR_R_LOF         1
`define LLAR_R_AISL        2
`define LLAR_R_EXT         3

`define LLAR_CLK_MHZ       200
`define LLAR_LOF_SET_US    3000

`endif

// *** hdl/llar_pkg.sv ***
/*
 * Types of the LOF alarm block.
 * Assumes the defines header is on the include path.
 */
package llar_pkg;
    typedef enum logic [1:0] {
        LLAR_IN_FRAME,
        LLAR_LOF,
        LLAR_RECOVER
    } llar_state_t;
    typedef logic [7:0] llar_byte_t;
endpackage

// *** hdl/llar_core.sv ***
/*
 * LOF declaration and clearance, defect and event bytes, remote defect and downstream
 * path alarm forcing, behind an APB slave.
 * Assumes frame_sync pulses once per frame, a1a2_ok is valid with it, and all defect
 * inputs are synchronous levels from the framer and detectors; event inputs are pulses.
 */
// Overview of operation
// - Status byte shows eight live defect flags.
// - Declare LOF after SEF held three milliseconds.
// - Clear LOF after SEF clears, N good frames.
// - LOF flag returns zero when LOF clears.
// - Any LOF change sets event bit two.
// - Event latch with its mask bit set pulls interrupt output low.
// - Event byte holds eight clear-on-read event bits.
// - RDI-L sent while LOF and enabled.
// - Remote defect control: four writable bits.
// - Downstream AIS-P while LOF, trigger and master.
// - Auto alarm byte holds a master bit and seven writable triggers.
// - Single-channel mode drives all four path alarms.
`timescale 1ns/100ps
`include "llar_defines.svh"

module llar_core #(
    parameter int unsigned LOF_SET_CYCLES = `LLAR_LOF_SET_US * `LLAR_CLK_MHZ
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [15:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              frame_sync,
    input  wire logic              a1a2_ok,
    input  wire logic              sef_defect,
    input  wire logic              los_defect,
    input  wire logic              sd_defect,
    input  wire logic              sf_defect,
    input  wire logic              s1_unstable,
    input  wire logic              k1k2_unstable,
    input  wire logic              rdil_defect,
    input  wire logic              aisl_defect,
    input  wire logic              optical_loss,
    input  wire logic              trace_mismatch,
    input  wire logic              trace_unstable,
    input  wire logic              ext_rdil_request,
    input  wire logic              b1_error,
    input  wire logic              b2_error,
    input  wire logic              reil_error,
    output logic                   int_n,
    output logic                   rdil_force,
    output logic [3:0]             path_ais
);
    import llar_pkg::*;

    llar_state_t        state;
    llar_byte_t         event_status;
    llar_byte_t         next_event;
    llar_byte_t         auto_ctl;
    llar_byte_t         int_mask;
    llar_byte_t         next_mask;
    llar_byte_t         defect_live;
    llar_byte_t         rd_word;
    logic [3:0]         rdi_ctl;
    logic [3:0]         insync_thr;
    logic [3:0]         good_cnt;
    logic [19:0]        sef_cnt;
    logic               single_mode;
    logic               lof;
    logic               lof_q;
    logic               los_q;
    logic               sef_q;
    logic               sd_q;
    logic               sf_q;
    logic               acc;
    logic               wr;
    logic               rd_event;
    logic               mapped;
    logic               want_rdi;
    logic               want_ais;
    logic [15:0]        idx;

    localparam logic [19:0] SET_LAST = 20'(LOF_SET_CYCLES - 1);

    assign lof = (state != LLAR_IN_FRAME);
    assign idx = {2'h0, paddr[15:2]};
    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;
    assign rd_event = acc && !pwrite && (idx == `LLAR_IDX_EVENT);
    // A mask write reaches the interrupt pin at the same edge as the register.
    assign next_mask = (wr && (idx == `LLAR_IDX_MASK)) ? pwdata[7:0] : int_mask;

    // Live defect byte; the LOF bit follows the current state both ways.
    assign defect_live = {rdil_defect, s1_unstable, k1k2_unstable, sf_defect,
                          sd_defect, lof, sef_defect, los_defect};

    // LOF state: declared on a long SEF run, cleared after good frames with SEF gone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= LLAR_IN_FRAME;
            sef_cnt  <= 20'h00000;
            good_cnt <= 4'h0;
        end else begin
            unique case (state)
                LLAR_IN_FRAME: begin
                    if (!sef_defect) begin
                        sef_cnt <= 20'h00000;
                    end else if (sef_cnt >= SET_LAST) begin
                        state <= LLAR_LOF;
                    end else begin
                        sef_cnt <= sef_cnt + 20'h00001;
                    end
                end
                LLAR_LOF: begin
                    sef_cnt  <= 20'h00000;
                    good_cnt <= 4'h0;
                    if (!sef_defect) begin
                        state <= LLAR_RECOVER;
                    end
                end
                LLAR_RECOVER: begin
                    if (sef_defect) begin
                        state <= LLAR_LOF;
                    end else if (good_cnt >= insync_thr) begin
                        state <= LLAR_IN_FRAME;
                    end else if (frame_sync) begin
                        good_cnt <= a1a2_ok ? good_cnt + 4'h1 : 4'h0;
                    end
                end
            endcase
        end
    end

    // Edge memory for the change-of-condition events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lof_q <= 1'b0;
            los_q <= 1'b0;
            sef_q <= 1'b0;
            sd_q  <= 1'b0;
            sf_q  <= 1'b0;
        end else begin
            lof_q <= lof;
            los_q <= los_defect;
            sef_q <= sef_defect;
            sd_q  <= sd_defect;
            sf_q  <= sf_defect;
        end
    end

    // A read clears the byte, but an event in the same cycle still lands.
    always_comb begin
        next_event = rd_event ? 8'h00 : event_status;
        next_event[`LLAR_B_LOF] = next_event[`LLAR_B_LOF] | (lof ^ lof_q);
        next_event[`LLAR_B_LOS] = next_event[`LLAR_B_LOS] | (los_defect ^ los_q);
        next_event[`LLAR_B_SEF] = next_event[`LLAR_B_SEF] | (sef_defect ^ sef_q);
        next_event[`LLAR_B_B1]  = next_event[`LLAR_B_B1] | b1_error;
        next_event[`LLAR_B_B2]  = next_event[`LLAR_B_B2] | b2_error;
        next_event[`LLAR_B_REI] = next_event[`LLAR_B_REI] | reil_error;
        next_event[`LLAR_E_SD] = next_event[`LLAR_E_SD] | (sd_defect ^ sd_q);
        next_event[`LLAR_E_SF] = next_event[`LLAR_E_SF] | (sf_defect ^ sf_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status <= 8'h00;
            int_n        <= 1'b1;
        end else begin
            event_status <= next_event;
            int_n        <= ~|(next_event & next_mask);
        end
    end

    // Software-written control.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_ctl    <= `LLAR_RST_AUTO;
            rdi_ctl     <= `LLAR_RST_RDI;
            int_mask    <= `LLAR_RST_MASK;
            insync_thr  <= `LLAR_RST_INSYNC;
            single_mode <= 1'b0;
        end else if (wr) begin
            if (idx == `LLAR_IDX_AUTO) begin
                auto_ctl <= pwdata[7:0];
            end
            if (idx == `LLAR_IDX_RDI) begin
                rdi_ctl <= pwdata[3:0];
            end
            if (idx == `LLAR_IDX_MASK) begin
                int_mask <= pwdata[7:0];
            end
            if (idx == `LLAR_IDX_INSYNC) begin
                insync_thr <= pwdata[3:0];
            end
            if (idx == `LLAR_IDX_MODE) begin
                single_mode <= pwdata[0];
            end
        end
    end

    assign want_rdi = (rdi_ctl[`LLAR_R_LOF] && lof) ||
                      (rdi_ctl[`LLAR_R_LOS] && los_defect) ||
                      (rdi_ctl[`LLAR_R_AISL] && aisl_defect) ||
                      (rdi_ctl[`LLAR_R_EXT] && ext_rdil_request);
    assign want_ais = auto_ctl[`LLAR_A_MASTER] &&
                      ((auto_ctl[`LLAR_A_LOF] && lof) ||
                       (auto_ctl[`LLAR_A_LOS] && los_defect) ||
                       (auto_ctl[`LLAR_A_LOC] && optical_loss) ||
                       (auto_ctl[`LLAR_A_SD] && sd_defect) ||
                       (auto_ctl[`LLAR_A_SF] && sf_defect) ||
                       (auto_ctl[`LLAR_A_TIM] && trace_mismatch) ||
                       (auto_ctl[`LLAR_A_TIU] && trace_unstable));

    // Forced alarms start at once and end only on a frame boundary, so the
    // far end never sees an alarm end part way through a frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdil_force <= 1'b0;
            path_ais   <= 4'h0;
        end else begin
            if (want_rdi) begin
                rdil_force <= 1'b1;
            end else if (frame_sync) begin
                rdil_force <= 1'b0;
            end
            if (want_ais) begin
                path_ais <= single_mode ? 4'hf : 4'h1;
            end else if (frame_sync) begin
                path_ais <= 4'h0;
            end
        end
    end

    always_comb begin
        mapped  = 1'b1;
        rd_word = 8'h00;
        unique case (idx)
            `LLAR_IDX_DEFECT: rd_word = defect_live;
            `LLAR_IDX_EVENT:  rd_word = event_status;
            `LLAR_IDX_AUTO:   rd_word = auto_ctl;
            `LLAR_IDX_RDI:    rd_word = {4'h0, rdi_ctl};
            `LLAR_IDX_MASK:   rd_word = int_mask;
            `LLAR_IDX_INSYNC: rd_word = {4'h0, insync_thr};
            `LLAR_IDX_MODE:   rd_word = {7'h00, single_mode};
            default:          mapped  = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= {24'h000000, rd_word};
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    sequence s_event_read;
        psel && penable && pready && !pwrite && (idx == `LLAR_IDX_EVENT);
    endsequence

    property p_ais_lof;
        @(posedge pclk) disable iff (!presetn)
        (lof && auto_ctl[`LLAR_A_LOF] && auto_ctl[`LLAR_A_MASTER]) |=> path_ais[0];
    endproperty
    a_ais_lof: assert property (p_ais_lof) else $error("no path alarm during lof");

    property p_rdi_lof;
        @(posedge pclk) disable iff (!presetn)
        (lof && rdi_ctl[`LLAR_R_LOF]) |=> rdil_force;
    endproperty
    a_rdi_lof: assert property (p_rdi_lof) else $error("no rdi during lof");

    property p_lof_event;
        @(posedge pclk) disable iff (!presetn)
        (lof != $past(lof)) |=> event_status[`LLAR_B_LOF];
    endproperty
    a_lof_event: assert property (p_lof_event) else $error("lof change not latched");

    property p_int_low;
        @(posedge pclk) disable iff (!presetn)
        ((event_status & int_mask) != 8'h00) |-> !int_n;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt not asserted");

    property p_declare;
        @(posedge pclk) disable iff (!presetn)
        $rose(lof) |-> $past(sef_defect) && ($past(sef_cnt) == SET_LAST);
    endproperty
    a_declare: assert property (p_declare) else $error("lof declared early");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(lof) |-> !$past(sef_defect) && ($past(good_cnt) >= $past(insync_thr));
    endproperty
    a_clear: assert property (p_clear) else $error("lof cleared early");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (rdil_force && !frame_sync) |=> rdil_force;
    endproperty
    a_hold: assert property (p_hold) else $error("rdi dropped off boundary");

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
        (s_event_read and (lof == lof_q) && !b1_error && !b2_error && !reil_error &&
         (los_defect == los_q) && (sef_defect == sef_q) && (sd_defect == sd_q) &&
         (sf_defect == sf_q)) |=> (event_status == 8'h00);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("event byte not cleared");

    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        $fell(lof) |-> !defect_live[`LLAR_B_LOF] ##1 event_status[`LLAR_B_LOF];
    endproperty
    a_flag: assert property (p_flag) else $error("lof flag stale");
endmodule

// *** verification/llar_far_model.sv ***
/*
 * Model of the downstream path units, their cell processors and the remote line terminal.
 * Assumes it shares pclk and presetn with the alarm block and watches its alarm outputs.
 */
`timescale 1ns/100ps

module llar_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       rdil_force,
    input  wire logic [3:0] path_ais,
    output logic [3:0]      path_ais_defect,
    output logic [3:0]      cell_delin_lost,
    output logic            remote_rdi
);
    // Each far unit follows its indication one cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            path_ais_defect <= 4'h0;
            cell_delin_lost <= 4'h0;
            remote_rdi      <= 1'b0;
        end else begin
            path_ais_defect <= path_ais;
            cell_delin_lost <= path_ais;
            remote_rdi      <= rdil_force;
        end
    end
endmodule

// *** verification/line_lof_alarm_response_bench.sv ***
/*
 * Self-checking bench of the LOF alarm block over APB, with frame and defect stimulus.
 * Assumes the defines header is on the include path; the LOF timer is shortened.
 */
`timescale 1ns/100ps
`include "llar_defines.svh"

`define CHK(nm, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module line_lof_alarm_response_bench;
    import llar_pkg::*;
    localparam int unsigned LSET = 16;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, int_n, rdil_force, errv, rrdi;
    logic        frame_sync = 1'b0, a1a2_ok = 1'b0, sef_defect = 1'b0, los_defect = 1'b0;
    logic        sd_defect = 1'b0, sf_defect = 1'b0, s1_unstable = 1'b0, k1k2_unstable = 1'b0;
    logic        rdil_defect = 1'b0, aisl_defect = 1'b0, optical_loss = 1'b0;
    logic        trace_mismatch = 1'b0, trace_unstable = 1'b0, ext_rdil_request = 1'b0;
    logic        b1_error = 1'b0, b2_error = 1'b0, reil_error = 1'b0;
    logic [3:0]  path_ais, pdef, lcd;
    int          error_cnt = 0, compares = 0;

    always #2.5 pclk = ~pclk;

    llar_core #(.LOF_SET_CYCLES(LSET)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .frame_sync, .a1a2_ok, .sef_defect, .los_defect, .sd_defect, .sf_defect,
        .s1_unstable, .k1k2_unstable, .rdil_defect, .aisl_defect, .optical_loss,
        .trace_mismatch, .trace_unstable, .ext_rdil_request, .b1_error, .b2_error,
        .reil_error, .int_n, .rdil_force, .path_ais
    );

    llar_far_model far (.pclk, .presetn, .rdil_force, .path_ais, .path_ais_defect(pdef),
                        .cell_delin_lost(lcd), .remote_rdi(rrdi));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string nm);
        apb(1'b0, idx, 8'h0);
        `CHK(nm, {24'h0, exp}, rdv)
        `CHK("pslverr", 1'b0, errv)
    endtask

    task automatic frame(input logic ok);
        @(posedge pclk);
        frame_sync <= 1'b1;
        a1a2_ok <= ok;
        @(posedge pclk);
        frame_sync <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic set_def(input logic [7:0] v);
        @(posedge pclk);
        {rdil_defect, s1_unstable, k1k2_unstable, sf_defect, sd_defect} <= v[7:3];
        sef_defect <= v[1];
        los_defect <= v[0];
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`LLAR_IDX_AUTO, 8'h05, "auto");
        rdc(`LLAR_IDX_RDI, 8'h02, "rdi");
        rdc(`LLAR_IDX_DEFECT, 8'h00, "defect");
        apb(1'b1, `LLAR_IDX_RDI, 8'hff);
        rdc(`LLAR_IDX_RDI, 8'h0f, "rdi upper");
        apb(1'b1, `LLAR_IDX_AUTO, 8'ha2);
        rdc(`LLAR_IDX_AUTO, 8'ha2, "auto rw");
        apb(1'b1, `LLAR_IDX_DEFECT, 8'hff);
        rdc(`LLAR_IDX_DEFECT, 8'h00, "defect ro");
        apb(1'b0, 16'h0004, 8'h0);
        `CHK("unmapped", 1'b1, errv)
        $display("test registers done");
        set_def(8'hfb);
        repeat (3) @(posedge pclk);
        rdc(`LLAR_IDX_DEFECT, 8'hfb, "live");
        set_def(8'h00);
        @(posedge pclk);
        {b1_error, b2_error, reil_error} <= 3'h7;
        @(posedge pclk);
        {b1_error, b2_error, reil_error} <= 3'h0;
        repeat (3) @(negedge pclk);
        `CHK("int_n", 1'b0, int_n)
        rdc(`LLAR_IDX_EVENT, 8'hfb, "events");
        rdc(`LLAR_IDX_EVENT, 8'h00, "cleared");
        @(negedge pclk);
        `CHK("int_n off", 1'b1, int_n)
        $display("test events done");
        apb(1'b1, `LLAR_IDX_RDI, 8'h02);
        apb(1'b1, `LLAR_IDX_AUTO, 8'h05);
        apb(1'b1, `LLAR_IDX_MODE, 8'h01);
        apb(1'b1, `LLAR_IDX_INSYNC, 8'h02);
        set_def(8'h02);
        repeat (LSET - 8) @(posedge pclk);
        rdc(`LLAR_IDX_DEFECT, 8'h02, "early");
        repeat (12) @(posedge pclk);
        rdc(`LLAR_IDX_DEFECT, 8'h06, "lof");
        @(negedge pclk);
        `CHK("rdil", 1'b1, rdil_force)
        `CHK("far rdi", 1'b1, rrdi)
        `CHK("ais4", 4'hf, path_ais)
        `CHK("far ais", 4'hf, pdef)
        `CHK("int_n lof", 1'b0, int_n)
        rdc(`LLAR_IDX_EVENT, 8'h06, "lof ev");
        set_def(8'h00);
        frame(1'b1);
        frame(1'b0);
        frame(1'b1);
        rdc(`LLAR_IDX_DEFECT, 8'h04, "held");
        frame(1'b1);
        rdc(`LLAR_IDX_DEFECT, 8'h00, "lof off");
        @(negedge pclk);
        `CHK("rdil kept", 1'b1, rdil_force)
        frame(1'b1);
        @(negedge pclk);
        `CHK("rdil gone", 1'b0, rdil_force)
        `CHK("ais gone", 4'h0, path_ais)
        rdc(`LLAR_IDX_EVENT, 8'h06, "clr ev");
        $display("test lof done");
        apb(1'b1, `LLAR_IDX_MODE, 8'h00);
        apb(1'b1, `LLAR_IDX_RDI, 8'h00);
        set_def(8'h02);
        repeat (LSET + 4) @(posedge pclk);
        @(negedge pclk);
        `CHK("rdil off", 1'b0, rdil_force)
        `CHK("ais1", 4'h1, path_ais)
        `CHK("far lcd", 4'h1, lcd)
        apb(1'b1, `LLAR_IDX_AUTO, 8'h04);
        frame(1'b1);
        @(negedge pclk);
        `CHK("master", 4'h0, path_ais)
        `CHK("far clr", 4'h0, pdef)
        set_def(8'h00);
        $display("test gating done");
        apb(1'b1, `LLAR_IDX_RDI, 8'h0c);
        apb(1'b1, `LLAR_IDX_AUTO, 8'hd9);
        @(posedge pclk);
        {aisl_defect, optical_loss} <= 2'h3;
        repeat (2) @(negedge pclk);
        `CHK("rdi aisl", 1'b1, rdil_force)
        `CHK("ais loc", 4'h1, path_ais)
        @(posedge pclk);
        {aisl_defect, optical_loss, ext_rdil_request, trace_mismatch, trace_unstable} <= 5'h07;
        frame(1'b1);
        @(negedge pclk);
        `CHK("rdi ext", 1'b1, rdil_force)
        `CHK("ais trace", 4'h1, path_ais)
        @(posedge pclk);
        {ext_rdil_request, trace_mismatch, trace_unstable} <= 3'h0;
        frame(1'b1);
        @(negedge pclk);
        `CHK("rdi end", 1'b0, rdil_force)
        `CHK("ais end", 4'h0, path_ais)
        $display("test triggers done");
        complete_run();
    end
endmodule
